// [rtl/meter_data_record_readout.sv]
// record fifo and the serial record readout of the energy calculator
`default_nettype none

module record_fifo
   import record_pkg::*;
#(
   parameter int WIDTH = REC_W,
   parameter int DEPTH = FIFO_DEPTH,
   parameter int AW = FIFO_AW
) (
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset
   input wire logic flush, // drop all content
   input wire logic inValid, // write request
   output logic inReady, // space available
   input wire logic [WIDTH-1:0] inData, // write word
   output logic outValid, // word available
   input wire logic outReady, // read accept
   output logic [WIDTH-1:0] outData // head word
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0] count;
   } fifo_state_t;

   fifo_state_t st;
   fifo_state_t next_st;
   logic doWrite;
   logic doRead;

   assign inReady = (st.count != (AW+1)'(DEPTH)) && !flush;
   assign outValid = (st.count != '0) && !flush;
   assign outData = st.mem[st.rdPtr];
   assign doWrite = inValid && inReady;
   assign doRead = outValid && outReady;

   always_comb begin
      next_st = st;
      if (doWrite) begin
         next_st.mem[st.wrPtr] = inData;
         next_st.wrPtr = AW'(st.wrPtr + 1'b1);
      end
      if (doRead) begin
         next_st.rdPtr = AW'(st.rdPtr + 1'b1);
      end
      if (doWrite && !doRead) begin
         next_st.count = (AW+1)'(st.count + 1'b1);
      end else if (doRead && !doWrite) begin
         next_st.count = (AW+1)'(st.count - 1'b1);
      end
      if (flush) begin
         next_st.wrPtr = '0;
         next_st.rdPtr = '0;
         next_st.count = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule : record_fifo

module meter_data_record_readout
   import record_pkg::*;
(
   input wire logic ref_clk, // 100 MHz clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic spiCsN, // reader select, active low
   input wire logic spiSclk, // reader serial clock, idles low
   output logic spiMiso, // record data out, msb first
   input wire logic prechargeCmd, // one-cycle precharge command pulse
   input wire logic restartBusy, // restart still running in the calculator
   input wire logic noNeutralSystem, // three-phase system without neutral
   input wire logic [CFG_BITS-1:0] configBits, // configuration latches
   input wire common_in_t commonIn, // three-phase and neutral values
   input wire phase_in_t [2:0] phaseIn, // per-phase values, index 0 = R
   output logic recordsInvalid // status bit 7 as seen by the reader
);
   rd_state_t st;
   rd_state_t next_st;
   logic [DATA_W-1:0] recData [NUM_RECORDS];
   logic [REC_W-1:0] recWord;
   logic fifoInValid;
   logic fifoInReady;
   logic fifoOutValid;
   logic fifoOutReady;
   logic [REC_W-1:0] fifoOutData;
   logic sclkFall;
   logic fundSel;
   logic hallSel;
   logic [11:0] periodSel;
   logic [11:0] status3Eff;

   // odd parity per nibble lane, seeded with the group number as the reader's check does
   function automatic logic [PAR_W-1:0] rec_parity(input logic [DATA_W-1:0] d,
                                                   input logic [2:0] grp);
      logic [PAR_W-1:0] x;
      x = {1'b0, grp};
      for (int n = 0; n < DATA_W / PAR_W; n++) begin
         x = x ^ d[n*PAR_W +: PAR_W];
      end
      return ~x;
   endfunction : rec_parity

   // per-phase status with bit 0 replaced by the no-load flag of this energy
   function automatic logic [7:0] phase_status(input logic [7:0] s, input logic nl);
      logic [7:0] r;
      r = s;
      r[PHASE_NO_LOAD_BIT] = nl;
      return r;
   endfunction : phase_status

   assign fundSel = configBits[CFG_FUND_SEL_BIT];
   assign hallSel = configBits[CFG_HALL_SEL_BIT];
   assign recordsInvalid = (st.restartCnt != RESTART_CYCLES) || restartBusy;

   always_comb begin
      status3Eff = commonIn.status3;
      status3Eff[STATUS_INVALID_BIT] = recordsInvalid;
      if (!phaseIn[0].status[PHASE_FREQ_BAD_BIT]) begin
         periodSel = phaseIn[0].period;
      end else if (!phaseIn[1].status[PHASE_FREQ_BAD_BIT]) begin
         periodSel = phaseIn[1].period;
      end else begin
         periodSel = phaseIn[2].period;
      end
   end

   // record images in reading order, index = group * 4 + record
   always_comb begin
      recData[0] = {commonIn.activeWb3, status3Eff[7:0]};
      recData[1] = {fundSel ? commonIn.reactiveFund3 : commonIn.reactive3,
                    status3Eff[11:8], commonIn.testModeSignals};
      recData[2] = {commonIn.fundActive3, commonIn.sysCmd};
      // period field already scaled by 2**PERIOD_SCALE_SHIFT in the calculator
      recData[3] = {periodSel,
                    hallSel ? commonIn.magneticDc : commonIn.neutralVoltDc};
      recData[7] = {commonIn.sumIrms, commonIn.iNMom};
      recData[11] = {hallSel ? commonIn.magneticRms : commonIn.neutralVoltRms,
                     commonIn.iNRms};
      for (int p = 0; p < 3; p++) begin
         recData[4+p] = {noNeutralSystem ? phaseIn[p].uLineMom : phaseIn[p].uMom,
                         phaseIn[p].iMom};
         recData[8+p] = {noNeutralSystem ? phaseIn[p].uLineRms : phaseIn[p].uRms,
                         phaseIn[p].iRms};
         recData[12+p] = {phaseIn[p].activeWb,
                          phase_status(phaseIn[p].status, phaseIn[p].noLoadActWb)};
         recData[16+p] = {fundSel ? phaseIn[p].reactiveFund : phaseIn[p].reactive,
                          phase_status(phaseIn[p].status, phaseIn[p].noLoadReact)};
         recData[20+p] = {phaseIn[p].fundActive,
                          phase_status(phaseIn[p].status, phaseIn[p].noLoadFund)};
         recData[24+p] = {phaseIn[p].swmAcc, phaseIn[p].elapsed};
      end
      for (int s = 0; s < 4; s++) begin
         recData[15+4*s] = configBits[s*CFG_SLICE_W +: CFG_SLICE_W];
      end
   end

   // words are frozen as they enter the fifo, so one record never mixes two updates
   always_comb begin
      if (st.recIdx < NUM_RECORDS) begin
         recWord = {rec_parity(recData[st.recIdx], st.recIdx[4:2]),
                    recData[st.recIdx]};
      end else begin
         recWord = '0;
      end
   end

   assign fifoInValid = (st.spiState != SPI_IDLE) && (st.recIdx < NUM_RECORDS);
   assign sclkFall = st.sclkPrev && !spiSclk;
   assign spiMiso = st.shiftReg[REC_W-1];

   always_comb begin
      next_st = st;
      fifoOutReady = 1'b0;
      next_st.sclkPrev = spiSclk;
      if (st.restartCnt != RESTART_CYCLES) begin
         next_st.restartCnt = RESTART_W'(st.restartCnt + 1'b1);
      end
      if (fifoInValid && fifoInReady) begin
         next_st.recIdx = 5'(st.recIdx + 1'b1);
      end
      case (st.spiState)
         SPI_IDLE: begin
            if (!spiCsN) begin
               next_st.recIdx = {st.grpPtr, 2'b00};
               next_st.spiState = SPI_LOAD;
            end else if (prechargeCmd && st.grpPtr != LAST_GROUP) begin
               next_st.grpPtr = 3'(st.grpPtr + 1'b1);
            end
         end
         SPI_LOAD: begin
            if (fifoOutValid) begin
               fifoOutReady = 1'b1;
               next_st.shiftReg = fifoOutData;
               next_st.bitCnt = '0;
               next_st.spiState = SPI_SHIFT;
            end
         end
         SPI_SHIFT: begin
            if (sclkFall) begin
               if (st.bitCnt == BITS_PER_WORD_M1) begin
                  // past the last record the line reads zero
                  fifoOutReady = fifoOutValid;
                  next_st.shiftReg = fifoOutValid ? fifoOutData : '0;
                  next_st.bitCnt = '0;
               end else begin
                  next_st.shiftReg = {st.shiftReg[REC_W-2:0], 1'b0};
                  next_st.bitCnt = 5'(st.bitCnt + 1'b1);
               end
            end
         end
         default: begin
            next_st.spiState = SPI_IDLE;
         end
      endcase
      if (spiCsN && st.spiState != SPI_IDLE) begin
         // reader stopped: sequence ends, pointer returns to group 0
         next_st.spiState = SPI_IDLE;
         next_st.shiftReg = '0;
         next_st.bitCnt = '0;
         next_st.recIdx = '0;
         next_st.grpPtr = '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   record_fifo #(
      .WIDTH(REC_W),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk(ref_clk),
      .rst(sys_rst),
      .flush(spiCsN),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData(recWord),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );
endmodule : meter_data_record_readout

`default_nettype wire

// [rtl/record_pkg.sv]
// constants, types and record layout of the meter data record readout
`default_nettype none

package record_pkg;

   localparam int REC_W = 32;
   localparam int DATA_W = 28;
   localparam int PAR_W = 4;
   localparam int GROUPS = 7;
   localparam int RECS_PER_GROUP = 4;
   localparam logic [4:0] NUM_RECORDS = 5'h1C;
   localparam logic [2:0] LAST_GROUP = 3'h6;
   localparam int CFG_BITS = 112;
   localparam int CFG_SLICE_W = 28;
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_AW = 5;
   // line period in seconds = field * 2**PERIOD_SCALE_SHIFT / f_mclk
   localparam int PERIOD_SCALE_SHIFT = 6;

   // configuration bit positions inside the 112-bit configuration word
   localparam int CFG_FUND_SEL_BIT = 40;
   localparam int CFG_HALL_SEL_BIT = 41;

   // status bit positions
   localparam int STATUS_INVALID_BIT = 7;
   localparam int PHASE_NO_LOAD_BIT = 0;
   localparam int PHASE_FREQ_BAD_BIT = 2;

   // restart time after reset during which records read as invalid
   localparam int RESTART_W = 8;
   localparam logic [RESTART_W-1:0] RESTART_CYCLES = 8'h40;

   localparam logic [4:0] BITS_PER_WORD_M1 = 5'h1F;

   typedef enum logic [1:0] {
      SPI_IDLE = 2'b00,
      SPI_LOAD = 2'b01,
      SPI_SHIFT = 2'b10
   } spi_state_t;

   typedef struct packed {
      logic [11:0] uMom;
      logic [11:0] uLineMom;
      logic [11:0] uRms;
      logic [11:0] uLineRms;
      logic [15:0] iMom;
      logic [15:0] iRms;
      logic [19:0] activeWb;
      logic [19:0] reactive;
      logic [19:0] reactiveFund;
      logic [19:0] fundActive;
      logic [19:0] swmAcc;
      logic [7:0] status;
      logic noLoadActWb;
      logic noLoadReact;
      logic noLoadFund;
      logic [7:0] elapsed;
      logic [11:0] period;
   } phase_in_t;

   typedef struct packed {
      logic [19:0] activeWb3;
      logic [19:0] reactive3;
      logic [19:0] reactiveFund3;
      logic [19:0] fundActive3;
      logic [11:0] status3;
      logic [3:0] testModeSignals;
      logic [7:0] sysCmd;
      logic [15:0] neutralVoltDc;
      logic [15:0] magneticDc;
      logic [11:0] sumIrms;
      logic [15:0] iNMom;
      logic [11:0] neutralVoltRms;
      logic [11:0] magneticRms;
      logic [15:0] iNRms;
   } common_in_t;

   typedef struct packed {
      spi_state_t spiState;
      logic [4:0] recIdx;
      logic [2:0] grpPtr;
      logic sclkPrev;
      logic [REC_W-1:0] shiftReg;
      logic [4:0] bitCnt;
      logic [RESTART_W-1:0] restartCnt;
   } rd_state_t;

endpackage : record_pkg

`default_nettype wire

// [tb/record_readout_checker.sv]
// port assertions for the serial record readout
`default_nettype none
module record_readout_checker (
   input wire logic ref_clk, // system clock
   input wire logic sys_rst, // synchronous reset
   input wire logic spiCsN, // reader select
   input wire logic spiSclk, // serial clock
   input wire logic spiMiso, // record data
   input wire logic restartBusy, // restart running
   input wire logic recordsInvalid // status bit 7
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sinceRst;
   // saturating age since reset release, for the restart window
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sinceRst <= 8'h00;
      end else if (sinceRst != 8'hFF) begin
         sinceRst <= sinceRst + 8'h01;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   property p_busy;
      restartBusy |-> recordsInvalid;
   endproperty
   a_busy: assert property (p_busy) else $error("valid while busy");
   property p_rel;
      $fell(sys_rst) |-> recordsInvalid [*8];
   endproperty
   a_rel: assert property (p_rel) else $error("valid after release");
   property p_win;
      sinceRst < 8'h3C |-> recordsInvalid;
   endproperty
   a_win: assert property (p_win) else $error("restart too short");
   property p_clr;
      sinceRst >= 8'h46 && !restartBusy |-> !recordsInvalid;
   endproperty
   a_clr: assert property (p_clr) else $error("stays invalid");
   property p_idle;
      spiCsN && $past(spiCsN) |-> !spiMiso;
   endproperty
   a_idle: assert property (p_idle) else $error("data out while idle");
   property p_hold;
      !spiCsN && !$past(spiCsN) && $past(spiSclk) |-> $stable(spiMiso);
   endproperty
   a_hold: assert property (p_hold) else $error("data moved on high clock");
   property p_first;
      $fell(spiCsN) |-> (!spiMiso) [*3];
   endproperty
   a_first: assert property (p_first) else $error("data too early");
   property p_rstout;
      $fell(sys_rst) |-> !spiMiso;
   endproperty
   a_rstout: assert property (p_rstout) else $error("data out after reset");
endmodule : record_readout_checker
bind meter_data_record_readout record_readout_checker chk_u (.ref_clk(ref_clk),
   .sys_rst(sys_rst), .spiCsN(spiCsN), .spiSclk(spiSclk), .spiMiso(spiMiso),
   .restartBusy(restartBusy), .recordsInvalid(recordsInvalid));
`default_nettype wire

// [tb/record_reader_model.sv]
// serial reader that clocks records out of the readout block
`default_nettype none
module record_reader_model (
   input wire logic ref_clk, // system clock
   output logic spiCsN, // reader select
   output logic spiSclk, // serial clock
   output logic prechargeCmd, // group skip pulse
   input wire logic spiMiso // record data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] got [0:31];
   initial begin
      spiCsN = 1'b1;
      spiSclk = 1'b0;
      prechargeCmd = 1'b0;
   end
   // clock stands low outside frames; bits sampled where the clock rises
   task automatic read_frame(input int nPre, input int nRec);
      for (int i = 0; i < nPre; i++) begin
         @(posedge ref_clk) prechargeCmd <= 1'b1;
         @(posedge ref_clk) prechargeCmd <= 1'b0;
      end
      @(posedge ref_clk) spiCsN <= 1'b0;
      repeat (5) @(posedge ref_clk);
      for (int b = 0; b < nRec * 32; b++) begin
         @(posedge ref_clk);
         got[b / 32][31 - b % 32] = spiMiso;
         spiSclk <= 1'b1;
         repeat (2) @(posedge ref_clk);
         spiSclk <= 1'b0;
         repeat (3) @(posedge ref_clk);
      end
      @(posedge ref_clk) spiCsN <= 1'b1;
      repeat (2) @(posedge ref_clk);
   endtask : read_frame
endmodule : record_reader_model
`default_nettype wire

// [tb/meter_data_record_readout_tb.sv]
// self-checking bench for the serial record readout
`default_nettype none
`define CHK(what, expv, gotv) begin checks_done++; if ((gotv) !== (expv)) begin errors++; \
   $display("[FAIL] %s exp %h got %h", what, expv, gotv); end end
module meter_data_record_readout_tb
   import record_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [223:0] C_PAT = {7{32'hC3A5_96E1}};
   localparam logic [639:0] P_PAT = {20{32'h5B2D_E874}};
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic spiCsN, spiSclk, spiMiso, prechargeCmd, restartBusy, noNeutralSystem, recordsInvalid;
   logic [CFG_BITS-1:0] configBits;
   common_in_t commonIn;
   phase_in_t [2:0] phaseIn;
   int errors = 0;
   int checks_done = 0;
   always #5 ref_clk = ~ref_clk;
   meter_data_record_readout dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .spiCsN(spiCsN),
      .spiSclk(spiSclk), .spiMiso(spiMiso), .prechargeCmd(prechargeCmd),
      .restartBusy(restartBusy), .noNeutralSystem(noNeutralSystem), .configBits(configBits),
      .commonIn(commonIn), .phaseIn(phaseIn), .recordsInvalid(recordsInvalid));
   record_reader_model rdr_u (.ref_clk(ref_clk), .spiCsN(spiCsN), .spiSclk(spiSclk),
      .prechargeCmd(prechargeCmd), .spiMiso(spiMiso));
   function automatic logic [31:0] exp_rec(input int g, input int r);
      logic [27:0] d;
      logic [3:0] p;
      phase_in_t ph;
      logic fs, hs, nn;
      logic [11:0] per;
      ph = phaseIn[r > 2 ? 0 : r];
      fs = configBits[CFG_FUND_SEL_BIT];
      hs = configBits[CFG_HALL_SEL_BIT];
      nn = noNeutralSystem;
      per = !phaseIn[0].status[2] ? phaseIn[0].period :
         (!phaseIn[1].status[2] ? phaseIn[1].period : phaseIn[2].period);
      case (g)
         0: case (r)
            0: d = {commonIn.activeWb3, restartBusy, commonIn.status3[6:0]};
            1: d = {fs ? commonIn.reactiveFund3 : commonIn.reactive3, commonIn.status3[11:8],
               commonIn.testModeSignals};
            2: d = {commonIn.fundActive3, commonIn.sysCmd};
            default: d = {per, hs ? commonIn.magneticDc : commonIn.neutralVoltDc};
         endcase
         1: d = r == 3 ? {commonIn.sumIrms, commonIn.iNMom} :
            {nn ? ph.uLineMom : ph.uMom, ph.iMom};
         2: d = r == 3 ? {hs ? commonIn.magneticRms : commonIn.neutralVoltRms, commonIn.iNRms} :
            {nn ? ph.uLineRms : ph.uRms, ph.iRms};
         3: d = {ph.activeWb, ph.status[7:1], ph.noLoadActWb};
         4: d = {fs ? ph.reactiveFund : ph.reactive, ph.status[7:1], ph.noLoadReact};
         5: d = {ph.fundActive, ph.status[7:1], ph.noLoadFund};
         default: d = {ph.swmAcc, ph.elapsed};
      endcase
      if (g > 2 && r == 3) begin
         d = configBits[(g - 3) * 28 +: 28];
      end
      p = g[3:0];
      for (int i = 0; i < 7; i++) begin
         p ^= d[4 * i +: 4];
      end
      return {~p, d};
   endfunction : exp_rec
   task automatic finish_test();
      $display("errors %0d checks_done %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   initial begin
      restartBusy = 1'b0;
      noNeutralSystem = 1'b0;
      configBits = {28'hE1D2C3B, 28'h4A5968F, 28'h7B60C1D, 28'h39A2E54};
      commonIn = C_PAT[$bits(common_in_t)-1:0];
      phaseIn = P_PAT[$bits(phaseIn)-1:0];
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (80) @(posedge ref_clk);
      // second pass flips every selector and holds the restart flag
      for (int pass = 0; pass < 2; pass++) begin
         rdr_u.read_frame(0, 29);
         for (int k = 0; k < 28; k++) begin
            `CHK("record", exp_rec(k / 4, k % 4), rdr_u.got[k])
         end
         `CHK("past end", 32'h0000_0000, rdr_u.got[28])
         configBits[CFG_FUND_SEL_BIT] <= 1'b1;
         configBits[CFG_HALL_SEL_BIT] <= 1'b1;
         noNeutralSystem <= 1'b1;
         restartBusy <= 1'b1;
         phaseIn[0].status[2] <= ~phaseIn[0].status[2];
         @(posedge ref_clk);
      end
      // seven skips runs past the last group, which must saturate
      for (int pre = 1; pre < 8; pre++) begin
         rdr_u.read_frame(pre, 4);
         for (int r = 0; r < 4; r++) begin
            `CHK("skipped group", exp_rec(pre > 6 ? 6 : pre, r), rdr_u.got[r])
         end
      end
      finish_test();
   end
   initial begin
      repeat (30000) @(posedge ref_clk);
      errors++;
      finish_test();
   end
endmodule : meter_data_record_readout_tb
`default_nettype wire
